// >>> rtl/lso_objects.sv
// process-data object bank: status words, measurements, regulation targets
// assumes the protocol stack presents one object access at a time on req
`timescale 1ns/100ps
`default_nettype none
module lso_objects (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // object access port
  input wire lso_pkg::lso_req_s req,
  output lso_pkg::lso_rsp_s rsp,
  // condition levels from the power stage, asynchronous
  input wire lso_pkg::lso_cond0_s cond0_in,
  input wire lso_pkg::lso_cond1_s cond1_in,
  // averaged measurements, on mclk
  input wire logic [31:0] current_sample,
  input wire logic current_sample_valid,
  input wire logic [31:0] terminal_volt_sample,
  input wire logic terminal_volt_sample_valid,
  input wire logic [31:0] sense_volt_sample,
  input wire logic sense_volt_sample_valid,
  input wire logic sense_enabled,
  input wire logic sense_engaged,
  // regulation mode, on mclk
  input wire logic cc_mode,
  input wire logic cv_mode,
  // regulation outputs
  output logic [31:0] current_target,
  output logic [31:0] voltage_target,
  output logic [31:0] active_target,
  output logic active_target_valid,
  // live status words
  output logic [31:0] status_word0,
  output logic [31:0] status_word1
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a target must be a finite number; nan or infinity would upset the loop
  function automatic logic is_finite(input logic [31:0] f);
    is_finite = (f[30:lso_pkg::FLOAT_EXP_LSB] != lso_pkg::FLOAT_EXP_ALL_ONES);
  endfunction : is_finite

  function automatic logic is_read_index(input logic [15:0] idx);
    case (idx)
      lso_pkg::IDX_STATUS0_RD,
      lso_pkg::IDX_STATUS1_RD,
      lso_pkg::IDX_MEAS_CURR_RD,
      lso_pkg::IDX_MEAS_VOLT_RD,
      lso_pkg::IDX_CURR_TGT_RD,
      lso_pkg::IDX_VOLT_TGT_RD: is_read_index = 1'b1;
      default: is_read_index = 1'b0;
    endcase
  endfunction : is_read_index

  // ---------------------------------------------------------------
  // condition synchronisers
  // ---------------------------------------------------------------
  lso_pkg::lso_cond0_s cond0;
  lso_pkg::lso_cond1_s cond1;
  logic [$bits(lso_pkg::lso_cond0_s)-1:0] cond0_raw;
  logic [$bits(lso_pkg::lso_cond1_s)-1:0] cond1_raw;

  lso_sync #(.W($bits(lso_pkg::lso_cond0_s))) u_sync0 (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(cond0_in),
    .sync_out(cond0_raw)
  );

  lso_sync #(.W($bits(lso_pkg::lso_cond1_s))) u_sync1 (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(cond1_in),
    .sync_out(cond1_raw)
  );

  assign cond0 = cond0_raw;
  assign cond1 = cond1_raw;

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  logic [31:0] next_status0;
  logic [31:0] next_status1;

  // pure mapping of present levels, nothing sticky; unnamed bits stay zero
  always_comb begin
    next_status0 = lso_pkg::STATUS_RESET;
    next_status0[0] = ~cond0.input_on;
    next_status0[1] = cond0.input_on;
    next_status0[4] = cond0.amp_trip_flag;
    next_status0[5] = cond0.high_volt_trip_flag;
    next_status0[6] = cond0.watt_trip_flag;
    next_status0[7] = cond0.sense_bounds_fault;
    next_status0[8] = cond0.low_volt_trip_flag;
    next_status0[9] = cond0.shutdown_request;
    next_status0[10] = cond0.linear_module_power_limit;
    next_status0[11] = cond0.resistor_power_limit;
    next_status0[12] = cond0.target_start_failed;
    next_status0[13] = cond0.target_start_pending;
    next_status0[14] = cond0.phase_amp_exceeded;
    next_status0[15] = cond0.link_corrupted;
    next_status0[16] = cond0.terminal_amp_rating_exceeded;
    next_status0[17] = cond0.terminal_volt_rating_exceeded;
    next_status0[18] = cond0.linear_module_overheat;
    next_status0[19] = cond0.aux_fuse_open;
    next_status0[20] = cond0.interlock_open;
    next_status0[22] = cond0.maintenance_due;
    next_status0[23] = cond0.diode_module_overheat;
    next_status0[24] = cond0.config_incompatible;
    next_status0[25] = cond0.firmware_stack_overrun;
    next_status0[26] = cond0.analog_input_fault;
    next_status0[27] = cond0.resistor_module_overheat;
    next_status0[28] = cond0.below_min_volt;
    next_status0[29] = cond0.regulation_lost_flag;
    next_status0[30] = cond0.target_upgrading;
  end

  always_comb begin
    next_status1 = lso_pkg::STATUS_RESET;
    next_status1[0] = cond1.missing_line_phase;
    next_status1[1] = cond1.input_fuse_open;
    next_status1[2] = cond1.fan_stalled;
    next_status1[4] = cond1.power_stage_overheat;
    next_status1[5] = cond1.filter_module_overheat;
    next_status1[6] = cond1.capacitor_overheat;
    next_status1[7] = cond1.magnetics_overheat;
    next_status1[16] = cond1.system_rating_invalid;
    next_status1[17] = cond1.firmware_mismatch;
  end

  // refreshed every cycle from the levels; no access path writes here
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status_word0 <= lso_pkg::STATUS_RESET;
      status_word1 <= lso_pkg::STATUS_RESET;
    end else begin
      status_word0 <= next_status0;
      status_word1 <= next_status1;
    end
  end

  // ---------------------------------------------------------------
  // measurements
  // ---------------------------------------------------------------
  logic [31:0] meas_current;
  logic [31:0] meas_terminal_volt;
  logic [31:0] meas_sense_volt;
  logic sense_seen;
  logic [31:0] meas_voltage;

  lso_capture #(.W(lso_pkg::WORD_W), .RESET_VAL(lso_pkg::MEAS_RESET)) u_cap_curr (
    .mclk(mclk),
    .nrst(nrst),
    .sample(current_sample),
    .sample_valid(current_sample_valid),
    .held(meas_current),
    .seen()
  );

  lso_capture #(.W(lso_pkg::WORD_W), .RESET_VAL(lso_pkg::MEAS_RESET)) u_cap_tvolt (
    .mclk(mclk),
    .nrst(nrst),
    .sample(terminal_volt_sample),
    .sample_valid(terminal_volt_sample_valid),
    .held(meas_terminal_volt),
    .seen()
  );

  lso_capture #(.W(lso_pkg::WORD_W), .RESET_VAL(lso_pkg::MEAS_RESET)) u_cap_svolt (
    .mclk(mclk),
    .nrst(nrst),
    .sample(sense_volt_sample),
    .sample_valid(sense_volt_sample_valid),
    .held(meas_sense_volt),
    .seen(sense_seen)
  );

  // sense reading only once one has arrived, else a stale zero would be reported
  assign meas_voltage = (sense_enabled && sense_engaged && sense_seen) ?
                        meas_sense_volt : meas_terminal_volt;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic take;
  logic both;
  logic wr_curr;
  logic wr_volt;
  logic wr_ok;
  logic rd_ok;

  assign take = req.rd | req.wr;
  assign both = req.rd & req.wr;
  assign wr_curr = req.wr && !req.rd && (req.index == lso_pkg::IDX_CURR_TGT_WR);
  assign wr_volt = req.wr && !req.rd && (req.index == lso_pkg::IDX_VOLT_TGT_WR);
  assign wr_ok = (wr_curr | wr_volt) && is_finite(req.wdata);
  // status and measure indices have no write form, so writes there fail
  assign rd_ok = req.rd && !req.wr && is_read_index(req.index);

  // ---------------------------------------------------------------
  // regulation targets
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      current_target <= lso_pkg::TARGET_RESET;
    end else if (wr_curr && is_finite(req.wdata)) begin
      current_target <= req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      voltage_target <= lso_pkg::TARGET_RESET;
    end else if (wr_volt && is_finite(req.wdata)) begin
      voltage_target <= req.wdata;
    end
  end

  // the loop follows the target of the mode in force; cc wins if both claimed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active_target <= lso_pkg::TARGET_RESET;
      active_target_valid <= 1'b0;
    end else if (cc_mode) begin
      active_target <= current_target;
      active_target_valid <= 1'b1;
    end else if (cv_mode) begin
      active_target <= voltage_target;
      active_target_valid <= 1'b1;
    end else begin
      active_target_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // response
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;

  // read mux has no side effects: status words are only sampled
  always_comb begin
    case (req.index)
      lso_pkg::IDX_STATUS0_RD: next_rdata = next_status0;
      lso_pkg::IDX_STATUS1_RD: next_rdata = next_status1;
      lso_pkg::IDX_MEAS_CURR_RD: next_rdata = meas_current;
      lso_pkg::IDX_MEAS_VOLT_RD: next_rdata = meas_voltage;
      lso_pkg::IDX_CURR_TGT_RD: next_rdata = current_target;
      lso_pkg::IDX_VOLT_TGT_RD: next_rdata = voltage_target;
      default: next_rdata = '0;
    endcase
  end

  // one cycle latency; rdata zero on writes and on every refused access
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.ack <= take;
      rsp.err <= take && (both || !(rd_ok || wr_ok));
      rsp.rdata <= rd_ok ? next_rdata : '0;
    end
  end

endmodule : lso_objects
`default_nettype wire

// >>> rtl/lso_pkg.sv
// constants, field layouts and carriers of the load status and setpoint object bank
// assumes one 50 MHz clock and an object access port driven by the protocol stack
// Summary of operation
// - status words read-only, live, never latched
// - reading status words clears nothing
// - status words are 32-bit flag words
// - word0 bit0 standby, bit1 loading
// - word0 bits 4-8 trips and sense fault
// - word0 bit9 internal shutdown request
// - word0 bits 10,11 module power limits
// - word0 bit12 boot failed, bit13 pending
// - word0 bits 16,17 terminal rating exceeded
// - word0 bits 18,23,27 module overheat
// - word0 bit29 regulation lost
// - word1 bits 0-2 phase, fuse, fan
// - word1 bits 4-7 temperature faults
// - questionable word subset, status layout may change
// - current measure: averaged float, read-only
// - voltage measure: terminal or engaged sense
// - current target float read-write, used in CC
// - voltage target float read-write, used in CV
package lso_pkg;

  // ---------------------------------------------------------------
  // object indices
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_STATUS0_RD = 16'h200d;
  localparam logic [15:0] IDX_STATUS1_RD = 16'h200e;
  localparam logic [15:0] IDX_MEAS_CURR_RD = 16'h2101;
  localparam logic [15:0] IDX_MEAS_VOLT_RD = 16'h2102;
  localparam logic [15:0] IDX_CURR_TGT_WR = 16'h2201;
  localparam logic [15:0] IDX_CURR_TGT_RD = 16'h2202;
  localparam logic [15:0] IDX_VOLT_TGT_WR = 16'h2203;
  localparam logic [15:0] IDX_VOLT_TGT_RD = 16'h2204;

  // ---------------------------------------------------------------
  // widths, reset values, float fields
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam logic [31:0] TARGET_RESET = 32'h0000_0000; // +0.0
  localparam logic [31:0] MEAS_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [7:0] FLOAT_EXP_ALL_ONES = 8'hff;
  localparam int FLOAT_EXP_LSB = 23;
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [31:0] wdata;
  } lso_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } lso_rsp_s;

  // conditions for word 0, one bit each, levels from the power stage
  typedef struct packed {
    logic input_on;
    logic amp_trip_flag;
    logic high_volt_trip_flag;
    logic watt_trip_flag;
    logic sense_bounds_fault;
    logic low_volt_trip_flag;
    logic shutdown_request;
    logic linear_module_power_limit;
    logic resistor_power_limit;
    logic target_start_failed;
    logic target_start_pending;
    logic phase_amp_exceeded;
    logic link_corrupted;
    logic terminal_amp_rating_exceeded;
    logic terminal_volt_rating_exceeded;
    logic linear_module_overheat;
    logic aux_fuse_open;
    logic interlock_open;
    logic maintenance_due;
    logic diode_module_overheat;
    logic config_incompatible;
    logic firmware_stack_overrun;
    logic analog_input_fault;
    logic resistor_module_overheat;
    logic below_min_volt;
    logic regulation_lost_flag;
    logic target_upgrading;
  } lso_cond0_s;

  typedef struct packed {
    logic missing_line_phase;
    logic input_fuse_open;
    logic fan_stalled;
    logic power_stage_overheat;
    logic filter_module_overheat;
    logic capacitor_overheat;
    logic magnetics_overheat;
    logic system_rating_invalid;
    logic firmware_mismatch;
  } lso_cond1_s;

endpackage : lso_pkg

// >>> rtl/lso_sync.sv
// two-flop synchroniser for a bundle of independent condition levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/100ps
`default_nettype none
module lso_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // first stage is read only by the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : lso_sync
`default_nettype wire

// >>> rtl/lso_capture.sv
// holds the latest averaged sample delivered by the measurement path
// assumes sample and strobe come from logic on mclk
`timescale 1ns/100ps
`default_nettype none
module lso_capture #(
  parameter int W = 32,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // sample in
  input wire logic [W-1:0] sample,
  input wire logic sample_valid,
  // held value
  output logic [W-1:0] held,
  output logic seen
);

  // value stands until the next strobe, reads never disturb it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      held <= RESET_VAL;
      seen <= 1'b0;
    end else if (sample_valid) begin
      held <= sample;
      seen <= 1'b1;
    end
  end

endmodule : lso_capture
`default_nettype wire

// >>> sim/lso_objects_props.sv
// checker for the object bank, sees only the top ports
// assumes one clock mclk and async low reset nrst
`timescale 1ns/100ps
`default_nettype none
module lso_objects_props (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // object port
  input wire lso_pkg::lso_req_s req,
  input wire lso_pkg::lso_rsp_s rsp,
  // conditions and modes
  input wire lso_pkg::lso_cond0_s cond0_in,
  input wire lso_pkg::lso_cond1_s cond1_in,
  input wire logic cc_mode,
  input wire logic cv_mode,
  // outputs
  input wire logic [31:0] current_target,
  input wire logic [31:0] active_target,
  input wire logic active_target_valid,
  input wire logic [31:0] status_word0,
  input wire logic [31:0] status_word1
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // a float write to the current target, exponent all ones or not
  wire logic cur_wr = req.wr && !req.rd && req.index == lso_pkg::IDX_CURR_TGT_WR;
  wire logic bad_exp = req.wdata[30:23] == 8'hff;
  chk_ack_next_cycle: assert property ((req.rd || req.wr) |=> rsp.ack)
    else $error("no answer after request");
  chk_ack_idle: assert property (!(req.rd || req.wr) |=> !rsp.ack)
    else $error("answer without request");
  chk_wr_rdata_zero: assert property (req.wr |=> rsp.rdata == 32'h0)
    else $error("write answer carries data");
  chk_nan_refused: assert property (cur_wr && bad_exp |=> rsp.err && $stable(current_target))
    else $error("non-finite target taken");
  chk_target_store: assert property (cur_wr && !bad_exp |=> !rsp.err && current_target == $past(req.wdata))
    else $error("current target not stored");
  // slow levels need three edges to reach the outputs
  chk_status_live: assert property ($stable(cond0_in)[*4] |-> status_word0[1:0] == {cond0_in.input_on,
    !cond0_in.input_on} && status_word0[29] == cond0_in.regulation_lost_flag)
    else $error("word0 not following conditions");
  chk_word1_live: assert property ($stable(cond1_in)[*4] |-> status_word1[7:0] == {cond1_in.magnetics_overheat,
    cond1_in.capacitor_overheat, cond1_in.filter_module_overheat, cond1_in.power_stage_overheat, 1'b0,
    cond1_in.fan_stalled, cond1_in.input_fuse_open, cond1_in.missing_line_phase})
    else $error("word1 not following conditions");
  chk_spare_zero: assert property (status_word0[3:2] == 2'h0 && !status_word0[21] && !status_word0[31]
    && status_word1[15:8] == 8'h0 && status_word1[31:18] == 14'h0)
    else $error("spare status bit set");
  chk_active_cc: assert property ($past(cc_mode) |-> active_target == $past(current_target))
    else $error("active target not current target");
  chk_active_valid: assert property (active_target_valid == $past(cc_mode || cv_mode))
    else $error("active valid wrong");
  cov_nan: cover property (cur_wr && bad_exp);
  cov_cc: cover property (cc_mode && active_target_valid);
  cov_trip: cover property (status_word0[4]);
endmodule : lso_objects_props
bind lso_objects lso_objects_props chk_u (.mclk, .nrst, .req, .rsp, .cond0_in, .cond1_in, .cc_mode, .cv_mode,
  .current_target, .active_target, .active_target_valid, .status_word0, .status_word1);
`default_nettype wire

// >>> sim/lso_host_model.sv
// network master model: one object access at a time
// assumes the answer comes within a few edges of the taking edge
`timescale 1ns/100ps
`default_nettype none
module lso_host_model (
  // clock
  input wire logic mclk,
  // object port
  output var lso_pkg::lso_req_s req,
  input wire lso_pkg::lso_rsp_s rsp
);
  // ----------------------------------------
  // access
  // ----------------------------------------
  initial req = '0;
  // request stands for its taking edge only; the answer is taken at the edge where ack is sampled high
  task automatic xfer(input logic rd, input logic wr, input logic [15:0] idx, input logic [31:0] wd,
    output logic ok, output logic err, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{rd, wr, idx, wd};
    @(posedge mclk);
    req <= '{1'b0, 1'b0, ~idx, ~wd};
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 4);
    ok = rsp.ack === 1'b1;
    err = rsp.err;
    rdata = rsp.rdata;
  endtask : xfer
endmodule : lso_host_model
`default_nettype wire

// >>> sim/lso_objects_test.sv
// self-checking bench for the object bank
// assumes the host model drives the object port
`timescale 1ns/100ps
`default_nettype none
module lso_objects_test;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  lso_pkg::lso_req_s req;
  lso_pkg::lso_rsp_s rsp;
  lso_pkg::lso_cond0_s cond0_in = '0;
  lso_pkg::lso_cond1_s cond1_in = '0;
  logic [31:0] isamp = '0, tsamp = '0, ssamp = '0;
  logic ivld = 0, tvld = 0, svld = 0, sen = 0, seng = 0, cc_mode = 0, cv_mode = 0;
  logic [31:0] current_target, voltage_target, active_target, status_word0, status_word1, rd;
  logic active_target_valid, ok, err;
  int num_errors = 0;
  int checks = 0;
  int pos0[27] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 22, 23, 24, 25, 26, 27, 28, 29, 30};
  int pos1[9] = '{0, 1, 2, 4, 5, 6, 7, 16, 17};
  // 50 MHz
  always #10 mclk = ~mclk;
  lso_objects dut_u (.mclk(mclk), .nrst(nrst), .req(req), .rsp(rsp), .cond0_in(cond0_in), .cond1_in(cond1_in),
    .current_sample(isamp), .current_sample_valid(ivld), .terminal_volt_sample(tsamp),
    .terminal_volt_sample_valid(tvld), .sense_volt_sample(ssamp), .sense_volt_sample_valid(svld),
    .sense_enabled(sen), .sense_engaged(seng), .cc_mode(cc_mode), .cv_mode(cv_mode),
    .current_target(current_target), .voltage_target(voltage_target), .active_target(active_target),
    .active_target_valid(active_target_valid), .status_word0(status_word0), .status_word1(status_word1));
  lso_host_model host_u (.mclk(mclk), .req(req), .rsp(rsp));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // one access, answer judged on error flag and data
  task automatic access(input logic r, input logic w, input logic [15:0] idx, input logic [31:0] wd,
    input logic xerr, input logic [31:0] xdata);
    host_u.xfer(r, w, idx, wd, ok, err, rd);
    if (!ok) begin
      num_errors++;
      complete_run();
    end else begin
      check({31'h0, err}, {31'h0, xerr});
      check(rd, xdata);
    end
  endtask : access
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : cycles
  // strobe one averaged sample
  task automatic strobe(input int which, input logic [31:0] val);
    @(posedge mclk);
    case (which)
      0: begin
        isamp <= val;
        ivld <= 1'b1;
      end
      1: begin
        tsamp <= val;
        tvld <= 1'b1;
      end
      default: begin
        ssamp <= val;
        svld <= 1'b1;
      end
    endcase
    @(posedge mclk);
    {ivld, tvld, svld} <= 3'h0;
  endtask : strobe
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_status0();
    logic [31:0] exp;
    check(status_word0, 32'h1);
    for (int i = 0; i < 27; i++) begin
      @(posedge mclk);
      cond0_in <= 27'h1 << (26 - i);
      cycles(4);
      exp = (i == 0) ? 32'h2 : (32'h1 | (32'h1 << pos0[i]));
      access(1, 0, lso_pkg::IDX_STATUS0_RD, 0, 0, exp);
      access(1, 0, lso_pkg::IDX_STATUS0_RD, 0, 0, exp);
      check(status_word0, exp);
    end
    @(posedge mclk);
    cond0_in <= '0;
    cycles(4);
    access(1, 0, lso_pkg::IDX_STATUS0_RD, 0, 0, 32'h1);
    access(0, 1, lso_pkg::IDX_STATUS0_RD, 32'hffffffff, 1, 0);
  endtask : t_status0
  task automatic t_status1();
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      cond1_in <= 9'h1 << (8 - i);
      cycles(4);
      access(1, 0, lso_pkg::IDX_STATUS1_RD, 0, 0, 32'h1 << pos1[i]);
    end
    @(posedge mclk);
    cond1_in <= '0;
    cycles(4);
    access(1, 0, lso_pkg::IDX_STATUS1_RD, 0, 0, 32'h0);
  endtask : t_status1
  task automatic t_meas();
    strobe(0, 32'h3fc00000);
    access(1, 0, lso_pkg::IDX_MEAS_CURR_RD, 0, 0, 32'h3fc00000);
    access(0, 1, lso_pkg::IDX_MEAS_CURR_RD, 32'h1, 1, 0);
    strobe(1, 32'h41200000);
    strobe(2, 32'h40a00000);
    sen <= 1'b1;
    access(1, 0, lso_pkg::IDX_MEAS_VOLT_RD, 0, 0, 32'h41200000);
    seng <= 1'b1;
    access(1, 0, lso_pkg::IDX_MEAS_VOLT_RD, 0, 0, 32'h40a00000);
    sen <= 1'b0;
    access(1, 0, lso_pkg::IDX_MEAS_VOLT_RD, 0, 0, 32'h41200000);
  endtask : t_meas
  task automatic t_targets();
    check(current_target, 32'h0);
    cc_mode <= 1'b1;
    access(0, 1, lso_pkg::IDX_CURR_TGT_WR, 32'hc0490fdb, 0, 0);
    access(1, 0, lso_pkg::IDX_CURR_TGT_RD, 0, 0, 32'hc0490fdb);
    cycles(2);
    check(active_target, 32'hc0490fdb);
    access(0, 1, lso_pkg::IDX_CURR_TGT_WR, 32'h7fc00000, 1, 0);
    access(1, 0, lso_pkg::IDX_CURR_TGT_RD, 0, 0, 32'hc0490fdb);
    access(0, 1, lso_pkg::IDX_VOLT_TGT_WR, 32'h7f800000, 1, 0);
    access(0, 1, lso_pkg::IDX_VOLT_TGT_WR, 32'h42c80000, 0, 0);
    access(1, 0, lso_pkg::IDX_VOLT_TGT_RD, 0, 0, 32'h42c80000);
    check(voltage_target, 32'h42c80000);
    cv_mode <= 1'b1;
    cycles(2);
    check(active_target, 32'hc0490fdb);
    cc_mode <= 1'b0;
    cycles(2);
    check(active_target, 32'h42c80000);
    check({31'h0, active_target_valid}, 32'h1);
    access(0, 1, lso_pkg::IDX_CURR_TGT_RD, 32'h1, 1, 0);
    access(1, 1, lso_pkg::IDX_CURR_TGT_RD, 32'h1, 1, 0);
    access(1, 0, 16'h2103, 0, 1, 0);
  endtask : t_targets
  // no mode in force, then a reset in mid-run brings both targets, status word0 and the current measure back
  task automatic t_reset();
    cv_mode <= 1'b0;
    cycles(2);
    check({31'h0, active_target_valid}, 32'h0);
    check(active_target, 32'h42c80000);
    nrst <= 1'b0;
    cycles(2);
    nrst <= 1'b1;
    cycles(4);
    check(current_target, 32'h0);
    check(voltage_target, 32'h0);
    check(status_word0, 32'h1);
    access(1, 0, lso_pkg::IDX_MEAS_CURR_RD, 0, 0, 32'h0);
  endtask : t_reset
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cycles(4);
    nrst <= 1'b1;
    cycles(4);
    t_status0();
    t_status1();
    t_meas();
    t_targets();
    t_reset();
    complete_run();
  end
endmodule : lso_objects_test
`default_nettype wire
